/* File: rtl/fuse_bank.sv */
// fuse array: bits only ever go from zero to one
`timescale 1ns/10ps
module fuse_bank #(
    parameter int BYTES = 15
) (
    // clock and virgin-die clear
    input  wire logic             ref_clk,
    input  wire logic             blank_rst,
    // zap port
    input  wire logic             zap_en,
    input  wire logic [3:0]       zap_addr,
    input  wire logic [7:0]       zap_bits,
    // whole image
    output logic [BYTES*8-1:0]    image
);
    logic [7:0] fuse_mem [BYTES];   // one word per fuse byte

    // blank_rst models an unprogrammed die, not the power-on reset
    always_ff @(posedge ref_clk or posedge blank_rst) begin
        if (blank_rst) begin
            for (int i = 0; i < BYTES; i++) begin
                fuse_mem[i] <= 8'h00;
            end
        end else if (zap_en && (int'(zap_addr) < BYTES)) begin
            // or-in only: a one can never fall back
            fuse_mem[zap_addr] <= fuse_mem[zap_addr] | zap_bits;
        end
    end

    // flatten for the controller
    always_comb begin
        for (int i = 0; i < BYTES; i++) begin
            image[i*8 +: 8] = fuse_mem[i];
        end
    end
endmodule

/* File: rtl/otp_config_pkg.sv */
// constants for the one-time-programmable configuration store
package otp_config_pkg;
    // map geometry
    localparam int          FUSE_BYTES   = 15;
    localparam int          ADDR_W       = 4;
    // byte offsets
    localparam logic [3:0] OFS_OSC_FACT  = 4'h0;
    localparam logic [3:0] OFS_THERM_BG  = 4'h1;
    localparam logic [3:0] OFS_PWRUP_ERR = 4'h2;
    localparam logic [3:0] OFS_NODE_CMD  = 4'h3;
    localparam logic [3:0] OFS_C11       = 4'h4;
    localparam logic [3:0] OFS_C12       = 4'h5;
    localparam logic [3:0] OFS_C13       = 4'h6;
    localparam logic [3:0] OFS_C21       = 4'h7;
    localparam logic [3:0] OFS_C22       = 4'h8;
    localparam logic [3:0] OFS_BAUD_DRV  = 4'h9;
    localparam logic [3:0] OFS_C23       = 4'hA;
    localparam logic [3:0] OFS_C31       = 4'hB;
    localparam logic [3:0] OFS_C32       = 4'hC;
    localparam logic [3:0] OFS_C33       = 4'hD;
    localparam logic [3:0] OFS_GRP_THERM = 4'hE;
    // field positions, byte power_up_and_error_options
    localparam int BIT_DEFAULT     = 7;
    localparam int BIT_ERR_OFF     = 6;
    localparam int BIT_TSEL_LOW    = 5;
    localparam int BIT_FACT_LOCK   = 4;
    // byte node_address_and_cmd_limit
    localparam int BIT_USER_LOCK_A = 7;
    localparam int BIT_CMD_LIMIT   = 6;
    // byte baud_driver_options
    localparam int BIT_TSEL_HIGH   = 2;
    localparam int BIT_LOW_BAUD    = 1;
    localparam int BIT_BALLAST     = 0;
    // byte group_and_thermal_options
    localparam int BIT_USER_LOCK_B = 7;
    localparam int BIT_MOD_RATE    = 6;
    localparam int BIT_THERM_REG   = 4;
    // lock masks and fixed content
    localparam logic [7:0] MASK_ALL        = 8'hFF;
    localparam logic [7:0] MASK_FACT_B2    = 8'h3F;
    localparam logic [7:0] MASK_LOCKB_B2   = 8'hE0;
    localparam logic [7:0] MASK_LOCKB_B3   = 8'h40;
    localparam logic [7:0] MASK_GROUP      = 8'h0F;
    localparam logic [7:0] MASK_LOCKB_BE   = 8'h50;
    localparam logic [7:0] WR_MASK_B9      = 8'h07;
    localparam logic [7:0] WR_MASK_BE      = 8'hDF;
    localparam logic [7:0] FIXED_B9        = 8'h40;
    localparam logic [7:0] FIXED_BE        = 8'h20;
    localparam logic [7:0] DIAG_BLANK      = 8'hFF;
    // timing
    localparam int CLK_HZ          = 50_000_000;
    localparam int MOD_RATE_LOW_HZ = 122;
    localparam int MOD_RATE_HI_HZ  = 244;
    localparam int MOD_LOW_CYCLES  = CLK_HZ / MOD_RATE_LOW_HZ;
    localparam int MOD_HI_CYCLES   = CLK_HZ / MOD_RATE_HI_HZ;
    localparam int MOD_CNT_W       = 20;
    // bring-up sequencing
    typedef enum logic [1:0] {
        ST_LOAD = 2'b00,
        ST_RUN  = 2'b01
    } load_state_t;
endpackage

/* File: rtl/otp_config_store.sv */
// configuration store: fuse programming, locks and power-on copy
//
// Function
// - bits start zero, zap sets one forever
// - one byte changed per program command
// - new fuses act only after power-on reset, except lock fuses, which act at once
// - bytes 0, 1, 2[3:0] hold circuit trims
// - factory lock blocks trim bytes, byte2[5:0]
// - user lock a blocks byte3, group bits
// - user lock b blocks coefficients and options
// - default bit turns leds on at power-up
// - error-off bit kills all leds on short
// - command limit passes only short-colour, intensity
// - byte3 low six bits are node address
// - low-baud bit: zero 9600, one 10400
// - modulation bit: zero 122 Hz, one 244 Hz
// - thermal bit enables regulation; bit5 fixed one
// - byte E low nibble is group identity
// - nine coefficients occupy full bytes
// - diagonal coefficients load FF when blank
`timescale 1ns/10ps
module otp_config_store #(
    parameter int MOD_LOW_CYCLES = otp_config_pkg::MOD_LOW_CYCLES,
    parameter int MOD_HI_CYCLES  = otp_config_pkg::MOD_HI_CYCLES
) (
    // clock, power-on reset, virgin die clear
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       blank_rst,
    // fuse program command from the frame decoder
    input  wire logic       prog_valid,
    input  wire logic [3:0] prog_addr,
    input  wire logic [7:0] prog_data,
    output logic            prog_done,
    output logic            prog_blocked,
    // fuse readback
    input  wire logic [3:0] rd_addr,
    output logic [7:0]      rd_data,
    // command filter
    input  wire logic       cmd_valid,
    input  wire logic       cmd_is_short_color,
    input  wire logic       cmd_is_intensity,
    output logic            cmd_accept,
    // cathode short detection and led kill
    input  wire logic [2:0] short_to_gnd,
    output logic [2:0]      led_off,
    // working copies: trims
    output logic [4:0]      oscillator_trim,
    output logic [2:0]      fuse_trim,
    output logic [3:0]      shutdown_trim,
    output logic [3:0]      reference_trim,
    output logic [3:0]      polarity_trim,
    // working copies: options
    output logic            leds_on_at_power_up,
    output logic            all_leds_off_on_error,
    output logic            thermal_select_low,
    output logic            thermal_select_high,
    output logic            command_limit,
    output logic [5:0]      node_address_bit,
    output logic            low_baud_10400,
    output logic            ballast_used,
    output logic            modulation_rate_select,
    output logic            thermal_regulation_enable,
    output logic [3:0]      group_identity,
    output logic            config_ready,
    output logic            mod_tick,
    // working copies: colour coefficients
    output logic [7:0]      cal_c11,
    output logic [7:0]      cal_c12,
    output logic [7:0]      cal_c13,
    output logic [7:0]      cal_c21,
    output logic [7:0]      cal_c22,
    output logic [7:0]      cal_c23,
    output logic [7:0]      cal_c31,
    output logic [7:0]      cal_c32,
    output logic [7:0]      cal_c33
);
    localparam int NB = otp_config_pkg::FUSE_BYTES;

    otp_config_pkg::load_state_t state_reg;   // bring-up sequencer
    logic [NB*8-1:0]             image;       // live fuse content
    logic                        zap_en;      // one-cycle zap strobe
    logic [7:0]                  zap_bits;    // bits really burnt
    logic [7:0]                  prot_mask;   // bits locked now
    logic [7:0]                  old_byte;    // target byte before zap
    logic                        lock_f;      // factory lock fuse
    logic                        lock_a;      // user lock a fuse
    logic                        lock_b;      // user lock b fuse
    localparam int MOD_CNT_W = otp_config_pkg::MOD_CNT_W;
    logic [MOD_CNT_W-1:0]        mod_cnt_reg; // modulation divider

    // pick one byte out of the flat image
    function automatic logic [7:0] byte_of(input logic [NB*8-1:0] img,
                                           input logic [3:0] a);
        byte_of = (int'(a) < NB) ? img[a*8 +: 8] : 8'h00;
    endfunction

    // bits of a byte that a command may burn at all
    function automatic logic [7:0] writable(input logic [3:0] a);
        case (a)
            otp_config_pkg::OFS_BAUD_DRV:  writable = otp_config_pkg::WR_MASK_B9;
            otp_config_pkg::OFS_GRP_THERM: writable = otp_config_pkg::WR_MASK_BE;
            4'hF:                          writable = 8'h00;
            default:                       writable = otp_config_pkg::MASK_ALL;
        endcase
    endfunction

    // bits that the three lock fuses protect in a byte
    function automatic logic [7:0] protect(input logic [3:0] a,
                                           input logic lf,
                                           input logic la,
                                           input logic lb);
        logic [7:0] m;
        m = 8'h00;
        case (a)
            otp_config_pkg::OFS_OSC_FACT,
            otp_config_pkg::OFS_THERM_BG: begin
                m = lf ? otp_config_pkg::MASK_ALL : 8'h00;
            end
            otp_config_pkg::OFS_PWRUP_ERR: begin
                m = (lf ? otp_config_pkg::MASK_FACT_B2 : 8'h00)
                  | (lb ? otp_config_pkg::MASK_LOCKB_B2 : 8'h00);
            end
            otp_config_pkg::OFS_NODE_CMD: begin
                m = (la ? otp_config_pkg::MASK_ALL : 8'h00)
                  | (lb ? otp_config_pkg::MASK_LOCKB_B3 : 8'h00);
            end
            otp_config_pkg::OFS_GRP_THERM: begin
                m = (la ? otp_config_pkg::MASK_GROUP : 8'h00)
                  | (lb ? otp_config_pkg::MASK_LOCKB_BE : 8'h00);
            end
            4'hF: begin
                m = 8'h00;                                        // unmapped
            end
            default: begin
                m = lb ? otp_config_pkg::MASK_ALL : 8'h00;
            end
        endcase
        protect = m;
    endfunction

    // diagonal coefficient: blank fuse byte falls back to full scale
    function automatic logic [7:0] diag(input logic [7:0] f);
        diag = (f == 8'h00) ? otp_config_pkg::DIAG_BLANK : f;
    endfunction

    fuse_bank #(
        .BYTES     (NB)
    ) u_fuse (
        .ref_clk   (ref_clk),
        .blank_rst (blank_rst),
        .zap_en    (zap_en),
        .zap_addr  (prog_addr),
        .zap_bits  (zap_bits),
        .image     (image)
    );

    // lock fuses act at once, not after reset, so a lock is never racy
    always_comb begin
        lock_f    = image[otp_config_pkg::OFS_PWRUP_ERR*8
                          + otp_config_pkg::BIT_FACT_LOCK];
        lock_a    = image[otp_config_pkg::OFS_NODE_CMD*8
                          + otp_config_pkg::BIT_USER_LOCK_A];
        lock_b    = image[otp_config_pkg::OFS_GRP_THERM*8
                          + otp_config_pkg::BIT_USER_LOCK_B];
        old_byte  = byte_of(image, prog_addr);
        prot_mask = protect(prog_addr, lock_f, lock_a, lock_b);
        // only the addressed byte, only unlocked bits
        zap_bits  = prog_data & writable(prog_addr) & ~prot_mask;
        zap_en    = prog_valid && (state_reg == otp_config_pkg::ST_RUN);
    end

    // sequencer: one copy cycle after reset release, then run
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= otp_config_pkg::ST_LOAD;
        end else begin
            case (state_reg)
                otp_config_pkg::ST_LOAD: state_reg <= otp_config_pkg::ST_RUN;
                otp_config_pkg::ST_RUN:  state_reg <= otp_config_pkg::ST_RUN;
                default:                 state_reg <= otp_config_pkg::ST_LOAD;
            endcase
        end
    end

    // program answer: done pulse, blocked when a wanted bit was refused
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prog_done    <= 1'b0;
            prog_blocked <= 1'b0;
        end else begin
            prog_done    <= zap_en;
            prog_blocked <= zap_en
                         && ((prog_data & ~old_byte & (prot_mask
                             | ~writable(prog_addr))) != 8'h00);
        end
    end

    // readback shows the fuses, fixed ones included
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else begin
            case (rd_addr)
                otp_config_pkg::OFS_BAUD_DRV:
                    rd_data <= byte_of(image, rd_addr)
                             | otp_config_pkg::FIXED_B9;
                otp_config_pkg::OFS_GRP_THERM:
                    rd_data <= byte_of(image, rd_addr)
                             | otp_config_pkg::FIXED_BE;
                default:
                    rd_data <= byte_of(image, rd_addr);
            endcase
        end
    end

    // power-on copy: later zaps do not reach the working set
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            oscillator_trim           <= 5'h00;
            fuse_trim                 <= 3'h0;
            shutdown_trim             <= 4'h0;
            reference_trim            <= 4'h0;
            polarity_trim             <= 4'h0;
            leds_on_at_power_up       <= 1'b0;
            all_leds_off_on_error     <= 1'b0;
            thermal_select_low        <= 1'b0;
            thermal_select_high       <= 1'b0;
            command_limit             <= 1'b0;
            node_address_bit          <= 6'h00;
            low_baud_10400            <= 1'b0;
            ballast_used              <= 1'b0;
            modulation_rate_select    <= 1'b0;
            thermal_regulation_enable <= 1'b0;
            group_identity            <= 4'h0;
            config_ready              <= 1'b0;
            cal_c11                   <= 8'h00;
            cal_c12                   <= 8'h00;
            cal_c13                   <= 8'h00;
            cal_c21                   <= 8'h00;
            cal_c22                   <= 8'h00;
            cal_c23                   <= 8'h00;
            cal_c31                   <= 8'h00;
            cal_c32                   <= 8'h00;
            cal_c33                   <= 8'h00;
        end else if (state_reg == otp_config_pkg::ST_LOAD) begin
            config_ready <= 1'b1;
            // circuit trims, not colour data
            oscillator_trim <= image[7:3];
            fuse_trim       <= image[2:0];
            shutdown_trim   <= image[15:12];
            reference_trim  <= image[11:8];
            polarity_trim   <= image[19:16];
            leds_on_at_power_up   <= image[16+otp_config_pkg::BIT_DEFAULT];
            all_leds_off_on_error <= image[16+otp_config_pkg::BIT_ERR_OFF];
            thermal_select_low    <= image[16+otp_config_pkg::BIT_TSEL_LOW];
            command_limit    <= image[24+otp_config_pkg::BIT_CMD_LIMIT];
            node_address_bit <= image[29:24];
            thermal_select_high <= image[72+otp_config_pkg::BIT_TSEL_HIGH];
            low_baud_10400   <= image[72+otp_config_pkg::BIT_LOW_BAUD];
            ballast_used     <= image[72+otp_config_pkg::BIT_BALLAST];
            modulation_rate_select
                <= image[112+otp_config_pkg::BIT_MOD_RATE];
            thermal_regulation_enable
                <= image[112+otp_config_pkg::BIT_THERM_REG];
            group_identity   <= image[115:112];
            // full-byte coefficients, diagonal with blank fallback
            cal_c11 <= diag(byte_of(image, otp_config_pkg::OFS_C11));
            cal_c12 <= byte_of(image, otp_config_pkg::OFS_C12);
            cal_c13 <= byte_of(image, otp_config_pkg::OFS_C13);
            cal_c21 <= byte_of(image, otp_config_pkg::OFS_C21);
            cal_c22 <= diag(byte_of(image, otp_config_pkg::OFS_C22));
            cal_c23 <= byte_of(image, otp_config_pkg::OFS_C23);
            cal_c31 <= byte_of(image, otp_config_pkg::OFS_C31);
            cal_c32 <= byte_of(image, otp_config_pkg::OFS_C32);
            cal_c33 <= diag(byte_of(image, otp_config_pkg::OFS_C33));
        end
    end

    // short response: the shorted leds, or all when error-off is fused
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            led_off <= 3'b000;
        end else if (all_leds_off_on_error && (short_to_gnd != 3'b000)) begin
            led_off <= 3'b111;
        end else begin
            led_off <= short_to_gnd;
        end
    end

    // command filter, held closed until the options are loaded
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cmd_accept <= 1'b0;
        end else begin
            cmd_accept <= cmd_valid && config_ready
                       && (!command_limit
                           || cmd_is_short_color
                           || cmd_is_intensity);
        end
    end

    // modulation period tick at 122 or 244 Hz
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mod_cnt_reg <= '0;
            mod_tick    <= 1'b0;
        end else if (mod_cnt_reg == (modulation_rate_select
                     ? MOD_CNT_W'(MOD_HI_CYCLES - 1)
                     : MOD_CNT_W'(MOD_LOW_CYCLES - 1))) begin
            mod_cnt_reg <= '0;
            mod_tick    <= 1'b1;
        end else begin
            mod_cnt_reg <= mod_cnt_reg + 1'b1;
            mod_tick    <= 1'b0;
        end
    end

    // a burnt bit never returns to zero
    AST_ONE_STICKS: assert property (@(posedge ref_clk) disable iff (blank_rst)
        ($past(image) & ~image) == '0)
        else $error("fuse bit fell from one to zero");

    // zap result is old or unlocked wanted bits
    AST_ZAP_RESULT: assert property (@(posedge ref_clk) disable iff (rst || blank_rst)
        zap_en |=> byte_of(image, $past(prog_addr))
                   == ($past(old_byte) | $past(zap_bits)))
        else $error("programmed byte has wrong value");

    // only the addressed byte may change
    AST_ONE_BYTE: assert property (@(posedge ref_clk) disable iff (rst || blank_rst)
        zap_en |=> (($past(image) ^ image)
                    & ~({{(NB*8-8){1'b0}}, 8'hFF} << ($past(prog_addr) * 8)))
                   == '0)
        else $error("command changed another byte");

    // locked bits survive a zap attempt
    AST_LOCK_HOLDS: assert property (@(posedge ref_clk) disable iff (rst || blank_rst)
        zap_en |=> ((byte_of(image, $past(prog_addr)) ^ $past(old_byte))
                    & $past(prot_mask)) == 8'h00)
        else $error("protected bit changed");

    // no fuse change without a command
    AST_NO_STRAY: assert property (@(posedge ref_clk) disable iff (rst || blank_rst)
        !zap_en |=> $stable(image))
        else $error("fuse image changed without command");

    // working set frozen once running
    AST_FROZEN: assert property (@(posedge ref_clk) disable iff (rst)
        (state_reg == otp_config_pkg::ST_RUN) |=>
            $stable(node_address_bit) && $stable(cal_c11)
            && $stable(leds_on_at_power_up) && $stable(group_identity))
        else $error("working copy changed after load");

    // blank diagonal loads full scale
    AST_DIAG_BLANK: assert property (@(posedge ref_clk) disable iff (rst || blank_rst)
        (state_reg == otp_config_pkg::ST_LOAD
         && byte_of(image, otp_config_pkg::OFS_C22) == 8'h00)
        |=> cal_c22 == 8'hFF)
        else $error("blank diagonal coefficient not full scale");

    // error-off kills all three leds
    AST_ALL_OFF: assert property (@(posedge ref_clk) disable iff (rst)
        (all_leds_off_on_error && short_to_gnd != 3'b000)
        |=> led_off == 3'b111)
        else $error("error-off did not kill all leds");

    // limited command set is refused
    AST_CMD_LIMIT: assert property (@(posedge ref_clk) disable iff (rst)
        (cmd_valid && command_limit && !cmd_is_short_color
         && !cmd_is_intensity) |=> !cmd_accept)
        else $error("limited command accepted");
endmodule

/* File: tb/fuse_master.sv */
// bus master model issuing fuse program commands
`timescale 1ns/10ps
module fuse_master (
    // clock
    input  wire logic       ref_clk,
    // program command
    output logic            prog_valid,
    output logic [3:0]      prog_addr,
    output logic [7:0]      prog_data,
    // answer
    input  wire logic       prog_done,
    input  wire logic       prog_blocked
);
    // idle at time zero
    initial begin
        prog_valid = 1'b0;
        prog_addr  = 4'h0;
        prog_data  = 8'h00;
    end
    // one byte per command; address and data scrambled once released
    task automatic burn(input logic [3:0] a, input logic [7:0] d,
                        output logic dn, output logic blk);
        @(posedge ref_clk);
        prog_valid <= 1'b1;
        prog_addr  <= a;
        prog_data  <= d;
        @(posedge ref_clk);
        prog_valid <= 1'b0;
        prog_addr  <= ~a;
        prog_data  <= ~d;
        #1;
        dn  = prog_done;
        blk = prog_blocked;
    endtask
endmodule

/* File: tb/tb.sv */
// testbench for the fuse configuration store
`timescale 1ns/10ps
module tb;
    logic       ref_clk = 1'b0, rst = 1'b1, blank_rst = 1'b1;
    logic       prog_valid, prog_done, prog_blocked;
    logic [3:0] prog_addr, rd_addr = 4'h0;
    logic [7:0] prog_data, rd_data;
    logic       cmd_valid = 1'b0, cmd_sc = 1'b0, cmd_int = 1'b0;
    logic       cmd_accept, leds_on, all_off, tsl, tsh, cmd_lim;
    logic [2:0] short_to_gnd = 3'h0, led_off;
    logic [5:0] node;
    logic       low_baud, ballast, mod_sel, therm, ready, tick;
    logic [3:0] grp;
    logic [7:0] c11, c12, c22, c33;
    int         miscompares = 0, comparisons = 0;
    // small modulation counts keep the run short
    otp_config_store #(.MOD_LOW_CYCLES(20), .MOD_HI_CYCLES(10)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .blank_rst(blank_rst),
        .prog_valid(prog_valid), .prog_addr(prog_addr),
        .prog_data(prog_data), .prog_done(prog_done),
        .prog_blocked(prog_blocked), .rd_addr(rd_addr), .rd_data(rd_data),
        .cmd_valid(cmd_valid), .cmd_is_short_color(cmd_sc),
        .cmd_is_intensity(cmd_int), .cmd_accept(cmd_accept),
        .short_to_gnd(short_to_gnd), .led_off(led_off),
        .oscillator_trim(), .fuse_trim(), .shutdown_trim(),
        .reference_trim(), .polarity_trim(),
        .leds_on_at_power_up(leds_on), .all_leds_off_on_error(all_off),
        .thermal_select_low(tsl), .thermal_select_high(tsh),
        .command_limit(cmd_lim), .node_address_bit(node),
        .low_baud_10400(low_baud), .ballast_used(ballast),
        .modulation_rate_select(mod_sel),
        .thermal_regulation_enable(therm), .group_identity(grp),
        .config_ready(ready), .mod_tick(tick), .cal_c11(c11), .cal_c12(c12),
        .cal_c13(), .cal_c21(), .cal_c22(c22), .cal_c23(), .cal_c31(),
        .cal_c32(), .cal_c33(c33));
    fuse_master mst_u (.ref_clk(ref_clk), .prog_valid(prog_valid),
        .prog_addr(prog_addr), .prog_data(prog_data),
        .prog_done(prog_done), .prog_blocked(prog_blocked));
    // 50 MHz clock
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    // compare and count
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] s);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    // readback takes one edge to register
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        rd_addr <= a;
        @(posedge ref_clk);
        #1 chk("rd_data", e, rd_data);
    endtask
    // program one byte, expect done and the given blocked flag
    task automatic pg(input logic [3:0] a, input logic [7:0] d,
                      input logic eb);
        logic dn, b;
        mst_u.burn(a, d, dn, b);
        chk("prog_done/blocked", {6'h00, 1'b1, eb}, {6'h00, dn, b});
    endtask
    // filter answer comes one edge after the command
    task automatic cmd(input logic s, input logic i, input logic e);
        @(posedge ref_clk);
        {cmd_valid, cmd_sc, cmd_int} <= {1'b1, s, i};
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        #1 chk("cmd_accept", {7'h00, e}, {7'h00, cmd_accept});
    endtask
    // one shorted cathode held for one edge
    task automatic sh(input logic [2:0] e);
        @(posedge ref_clk);
        short_to_gnd <= 3'h1;
        @(posedge ref_clk);
        short_to_gnd <= 3'h0;
        #1 chk("led_off", {5'h00, e}, {5'h00, led_off});
    endtask
    // count modulation ticks over a window of n edges
    task automatic ticks(input int n, input logic [7:0] e);
        logic [7:0] c;
        c = 8'h00;
        repeat (n) begin
            @(posedge ref_clk);
            #1 c += {7'h00, tick};
        end
        chk("mod_tick", e, c);
    endtask
    // power-on reset; programming only from the second edge after it
    task automatic por;
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask
    // verdict
    task automatic wrap_up;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog well beyond the expected run
    initial begin
        #200000;
        miscompares++;
        wrap_up;
    end
    // main sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        {rst, blank_rst} <= 2'b00;
        repeat (2) @(posedge ref_clk);
        rd(4'h0, 8'h00);
        rd(4'h9, 8'h40);
        rd(4'hE, 8'h20);
        chk("coeffs", 8'hFF, c11 & c22 & c33);
        chk("c12", 8'h00, c12);
        cmd(1'b0, 1'b0, 1'b1);
        sh(3'h1);
        pg(4'h3, 8'h4A, 1'b0);
        pg(4'h3, 8'h21, 1'b0);
        rd(4'h3, 8'h6B);
        chk("node", 8'h00, {2'b00, node});
        pg(4'h2, 8'hD0, 1'b0);
        pg(4'h0, 8'h80, 1'b1);
        rd(4'h0, 8'h00);
        pg(4'h4, 8'h5A, 1'b0);
        pg(4'hD, 8'h33, 1'b0);
        pg(4'h9, 8'h02, 1'b0);
        pg(4'h9, 8'h01, 1'b0);
        ticks(40, 8'h02);
        pg(4'hE, 8'h5B, 1'b0);
        rd(4'hE, 8'h7B);
        pg(4'h3, 8'h80, 1'b0);
        pg(4'hE, 8'h04, 1'b1);
        rd(4'hE, 8'hFB - 8'h80);
        pg(4'hE, 8'h80, 1'b0);
        pg(4'h5, 8'h01, 1'b1);
        rd(4'h5, 8'h00);
        rd(4'h4, 8'h5A);
        por;
        chk("node", 8'h2B, {2'b00, node});
        chk("opts", 8'hFC, {leds_on, all_off, cmd_lim, mod_sel, therm,
            low_baud, tsl, tsh});
        chk("group", 8'h8B, {ballast, 3'h0, grp});
        ticks(40, 8'h04);
        chk("c11", 8'h5A, c11);
        chk("c33", 8'h33, c33);
        chk("c22", 8'hFF, c22);
        cmd(1'b0, 1'b0, 1'b0);
        cmd(1'b1, 1'b0, 1'b1);
        cmd(1'b0, 1'b1, 1'b1);
        sh(3'h7);
        wrap_up;
    end
endmodule
